// ---- core/spc_params.svh ----
// register map, field positions and reset values of the shared port
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH
`define SPC_ADDR_PIN_LEVELS   12'h000
`define SPC_ADDR_OUT_LATCH    12'h004
`define SPC_ADDR_DIRECTION    12'h008
`define SPC_ADDR_PERIPH_CTRL  12'h00C
`define SPC_DIR_RESET         8'hFF
`define SPC_LATCH_RESET       8'h00
`define SPC_CTRL_RESET        8'h01
`define SPC_CTRL_PINSEL_BIT   0
`define SPC_CTRL_EXTMODE_BIT  1
`define SPC_PIN_OSC_OUT       0
`define SPC_PIN_OSC_IN        1
`define SPC_PIN_CCU1          2
`define SPC_PIN_SCLK          3
`define SPC_WIDTH             8
`define SPC_SYNC_RESET        8'h00
`define SPC_OE_N_RESET        8'hFF
`define SPC_OUT_RESET         8'h00
`define SPC_RDATA_RESET       32'h0000_0000
`endif

// ---- core/spc_pkg.sv ----
// types shared by the shared port c block
package spc_pkg;
  // drive request of one on-chip peripheral onto its pin
  typedef struct packed {
    logic en;       // peripheral owns the output
    logic data;     // level it drives
    logic tristate; // peripheral asks for high impedance
  } spc_drive_t;
  // serial unit mode seen by the port
  typedef enum logic [1:0] {
    SPC_SER_OFF,
    SPC_SER_SPI,
    SPC_SER_I2C
  } spc_ser_mode_t;
endpackage

// ---- core/spc_port.sv ----
// shared port c: eight-pin gpio with peripheral pin takeover, apb slave
`timescale 1ns/1ps
`include "spc_params.svh"
module spc_port
(
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // pins: input, output, active-low output enable
  input  wire logic [7:0]             pin_in,
  output logic      [7:0]             pin_out,
  output logic      [7:0]             pin_oe_n,
  // slow timer oscillator and counter input
  input  wire logic                   slow_osc_en,
  output logic                        timer_count_input,
  output logic                        slow_osc_active,
  // second capture/compare unit and its pwm channel a
  input  wire spc_pkg::spc_drive_t    ccu2_drive,
  output logic                        ccu2_capture_in,
  output logic                        ccu2_alt_pin_req,
  // first capture/compare unit and its pwm channel a
  input  wire spc_pkg::spc_drive_t    ccu1_drive,
  output logic                        ccu1_capture_in,
  // synchronous serial unit clock
  input  wire spc_pkg::spc_ser_mode_t ser_mode,
  input  wire spc_pkg::spc_drive_t    ser_clk_drive,
  output logic                        ser_clk_in
);
  import spc_pkg::*;

  // ********************************************************
  // overview
  // ********************************************************
  // the port keeps three software registers: direction, output
  // latch and a small peripheral control word. a pin drives its latch
  // bit only when its direction bit is 0 and no peripheral claims it.
  // peripherals win over the latch on their own pins:
  //   pin 0 - slow oscillator output, timer count input
  //   pin 1 - slow oscillator input, second capture unit
  //   pin 2 - first capture unit and its pwm channel a
  //   pin 3 - serial unit clock, spi or i2c
  // pins 4 to 7 are plain gpio in this block.
  // every pin output and every peripheral input is registered, so
  // a change shows one clock after the state that caused it; the
  // extra cycle buys glitch-free pads at the cost of latency.
  // pin levels pass a two-stage synchroniser before anything reads
  // them, so a read of the level register lags the pad by two
  // clocks plus the bus setup cycle.
  // the oscillator has the last word on pins 0 and 1: while it
  // runs, no other request can turn their drivers on.
  // software must still set direction bits for each peripheral but the oscillator and the i2c clock;
  // the port never rewrites them, so a read returns what was set.
  // the apb slave never stretches a transfer: pready is high from
  // the first clock after reset and every access takes one cycle.
  // the control word holds the pin select and the extended mode
  // bit; the unit only leaves pin 1 when both agree on it.
  // the i2c clock is modelled open-drain: it pulls low or lets go,
  // and never drives the pin high itself.
  // capture and clock inputs read 0 whenever their path is not
  // selected, so an idle peripheral sees a quiet line.

  // ********************************************************
  // register state
  // ********************************************************
  logic [7:0] dir_q;
  logic [7:0] latch_q;
  logic [7:0] ctrl_q;
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] wbyte;
  logic       ccu2_on_pin1;
  logic [7:0] oe_n_d;
  logic [7:0] out_d;
  logic [31:0] rdata_d;
  logic       bad_addr;
  logic       wr_dir;
  logic       wr_latch;
  logic       wr_ctrl;
  logic       ccu2_out_sel;
  logic       ccu1_out_sel;
  logic       spi_out_sel;
  logic       i2c_out_sel;

  // writes strobe in the access phase, reads in setup; pready is held high, so one phase
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  // only byte lane 0 carries data; narrow registers ignore the rest
  assign wbyte = pwdata[7:0];

  // one write strobe per register; the lane 0 strobe gates them all
  assign wr_dir   = wr_en & pstrb[0] & (paddr == `SPC_ADDR_DIRECTION);
  // the data register and the latch register both reach the latch
  assign wr_latch = wr_en & pstrb[0] &
                    ((paddr == `SPC_ADDR_PIN_LEVELS) |
                     (paddr == `SPC_ADDR_OUT_LATCH));
  assign wr_ctrl  = wr_en & pstrb[0] & (paddr == `SPC_ADDR_PERIPH_CTRL);

  // ********************************************************
  // apb register writes
  // ********************************************************
  // direction resets to all inputs, peripherals never change it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dir_q <= `SPC_DIR_RESET;
    else if (wr_dir)
      dir_q <= wbyte;
  end

  // data register and latch register both write the latch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      latch_q <= `SPC_LATCH_RESET;
    else if (wr_latch)
      latch_q <= wbyte;
  end

  // pin select and extended mode configuration bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= `SPC_CTRL_RESET;
    else if (wr_ctrl)
      ctrl_q <= {6'h00, wbyte[`SPC_CTRL_EXTMODE_BIT],
                 wbyte[`SPC_CTRL_PINSEL_BIT]};
  end

  // ********************************************************
  // pin input synchroniser
  // ********************************************************
  // first stage may go metastable; nothing but stage two reads it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync1_q <= `SPC_SYNC_RESET;
    else
      sync1_q <= pin_in;
  end

  // second stage is the only pin level seen by the logic
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync2_q <= `SPC_SYNC_RESET;
    else
      sync2_q <= sync1_q;
  end

  // ********************************************************
  // read mux
  // ********************************************************
  // read data captured in setup so it is stable during access
  always_comb
  begin
    rdata_d  = 32'h0000_0000;
    bad_addr = 1'b0;
    case (paddr)
      `SPC_ADDR_PIN_LEVELS:  rdata_d = {24'h000000, sync2_q};
      `SPC_ADDR_OUT_LATCH:   rdata_d = {24'h000000, latch_q};
      `SPC_ADDR_DIRECTION:   rdata_d = {24'h000000, dir_q};
      `SPC_ADDR_PERIPH_CTRL: rdata_d = {24'h000000, ctrl_q};
      default:               bad_addr = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= `SPC_RDATA_RESET;
    else if (rd_en)
      prdata <= rdata_d;
  end

  // zero wait states: ready rises on the first edge after reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= 1'b1;
  end

  // unmapped addresses answer with an error in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= psel & ~penable & bad_addr;
  end

  // ********************************************************
  // pin ownership
  // ********************************************************
  // alternate placement only exists in extended mode
  assign ccu2_on_pin1 = ctrl_q[`SPC_CTRL_PINSEL_BIT] |
                        ~ctrl_q[`SPC_CTRL_EXTMODE_BIT];

  // pin 1 peripheral drive needs the unit placed there and dir 0
  assign ccu2_out_sel = ccu2_on_pin1 & ccu2_drive.en &
                        ~dir_q[`SPC_PIN_OSC_IN];
  // pin 2 peripheral drive needs dir 0
  assign ccu1_out_sel = ccu1_drive.en & ~dir_q[`SPC_PIN_CCU1];
  // spi clock drives only as an output, direction 0
  assign spi_out_sel  = (ser_mode == SPC_SER_SPI) & ~dir_q[`SPC_PIN_SCLK];
  // i2c clock overrides whatever the direction bit holds
  assign i2c_out_sel  = (ser_mode == SPC_SER_I2C) & ser_clk_drive.en;

  // priority per pin: oscillator, peripheral, then latch/direction
  always_comb
  begin
    oe_n_d = dir_q;
    out_d  = latch_q;
    // pin 1: second unit output or pwm channel a
    if (ccu2_out_sel)
    begin
      out_d[`SPC_PIN_OSC_IN]  = ccu2_drive.data;
      oe_n_d[`SPC_PIN_OSC_IN] = ccu2_drive.tristate;
    end
    // pin 2: first unit output or pwm channel a
    if (ccu1_out_sel)
    begin
      out_d[`SPC_PIN_CCU1]  = ccu1_drive.data;
      oe_n_d[`SPC_PIN_CCU1] = ccu1_drive.tristate;
    end
    // pin 3: serial clock; i2c output works open-drain style
    if (spi_out_sel)
    begin
      out_d[`SPC_PIN_SCLK]  = ser_clk_drive.data;
      oe_n_d[`SPC_PIN_SCLK] = 1'b0;
    end
    else if (i2c_out_sel)
    begin
      out_d[`SPC_PIN_SCLK]  = 1'b0;
      oe_n_d[`SPC_PIN_SCLK] = ser_clk_drive.data;
    end
    // oscillator owns pins 0 and 1 as analog, digital driver off
    if (slow_osc_en)
    begin
      oe_n_d[`SPC_PIN_OSC_OUT] = 1'b1;
      oe_n_d[`SPC_PIN_OSC_IN]  = 1'b1;
      out_d[`SPC_PIN_OSC_OUT]  = 1'b0;
      out_d[`SPC_PIN_OSC_IN]   = 1'b0;
    end
  end

  // registered drive enables; a reset leaves every driver off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_oe_n <= `SPC_OE_N_RESET;
    else
      pin_oe_n <= oe_n_d;
  end

  // registered drive levels, low until someone drives
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_out <= `SPC_OUT_RESET;
    else
      pin_out <= out_d;
  end

  // ********************************************************
  // peripheral inputs from pins
  // ********************************************************
  // timer count input from pin 0, dead while the oscillator runs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_count_input <= 1'b0;
    else
      timer_count_input <= ~slow_osc_en & dir_q[`SPC_PIN_OSC_OUT] &
                           sync2_q[`SPC_PIN_OSC_OUT];
  end

  // second unit capture needs the unit on pin 1 and direction 1
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ccu2_capture_in <= 1'b0;
    else
      ccu2_capture_in <= ~slow_osc_en & ccu2_on_pin1 &
                         dir_q[`SPC_PIN_OSC_IN] &
                         sync2_q[`SPC_PIN_OSC_IN];
  end

  // first unit capture follows pin 2 while it is an input
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ccu1_capture_in <= 1'b0;
    else
      ccu1_capture_in <= dir_q[`SPC_PIN_CCU1] &
                         sync2_q[`SPC_PIN_CCU1];
  end

  // serial clock input; the i2c buffer type is the unit's business,
  // here it is just one sampled level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ser_clk_in <= 1'b0;
    else
      ser_clk_in <= ((ser_mode == SPC_SER_I2C) |
                     dir_q[`SPC_PIN_SCLK]) &
                    sync2_q[`SPC_PIN_SCLK];
  end

  // tells the oscillator that pins 0 and 1 are now its own
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      slow_osc_active <= 1'b0;
    else
      slow_osc_active <= slow_osc_en;
  end

  // asks the device to route the second unit to its other pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ccu2_alt_pin_req <= 1'b0;
    else
      ccu2_alt_pin_req <= ~ccu2_on_pin1;
  end
endmodule

// ---- tb/spc_board.sv ----
// board model that resolves the eight port pins
`timescale 1ns/1ps
module spc_board
(
  // port side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  // external drivers
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_in
);
  // the port wins where it drives; an undriven line sits on its pull-up,
  // so a released pin never shows a stale level
  assign pin_in = (~pin_oe_n & pin_out)
                | (pin_oe_n & ((ext_en & ext_val) | ~ext_en));
endmodule

// ---- tb/spc_port_props.sv ----
// concurrent checks on the shared port outputs
`timescale 1ns/1ps
module spc_port_props
(
  // clock, reset and apb
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [11:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [3:0]             pstrb,
  input wire logic                   pslverr,
  // pins and peripherals
  input wire logic [7:0]             pin_out,
  input wire logic [7:0]             pin_oe_n,
  input wire logic                   slow_osc_en,
  input wire logic                   slow_osc_active,
  input wire logic                   timer_count_input,
  input wire logic                   ccu1_capture_in,
  input wire logic                   ccu2_alt_pin_req,
  input wire spc_pkg::spc_ser_mode_t ser_mode,
  input wire spc_pkg::spc_drive_t    ser_clk_drive
);
  import spc_pkg::*;
  // ************
  // properties
  // ************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rst; $rose(presetn) |-> pin_oe_n == 8'hFF; endproperty
  a_rst: assert property (p_rst) else $error("pins not inputs");
  property p_alt; $rose(presetn) |-> !ccu2_alt_pin_req; endproperty
  a_alt: assert property (p_alt) else $error("unit moved");
  property p_osc; slow_osc_en |=> pin_oe_n[1:0] == 2'h3; endproperty
  a_osc: assert property (p_osc) else $error("osc pins");
  property p_tci; timer_count_input |-> !slow_osc_active; endproperty
  a_tci: assert property (p_tci) else $error("count in");
  property p_cap; ccu1_capture_in |-> pin_oe_n[2]; endproperty
  a_cap: assert property (p_cap) else $error("capture");
  property p_err; psel && !penable && paddr == 12'h010 |=> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("no slverr");
  // pulling low needs no direction bit, so the pin must drive low
  property p_scl; ser_mode == SPC_SER_I2C && ser_clk_drive.en
    && !ser_clk_drive.data |=> !pin_oe_n[3] && !pin_out[3]; endproperty
  a_scl: assert property (p_scl) else $error("i2c clock");
  property p_lat; psel && penable && pwrite && pstrb[0] && paddr == 12'h004
    && pin_oe_n[7:4] == 4'h0 |-> ##2 pin_out[7:4] == $past(pwdata[7:4], 2);
  endproperty
  a_lat: assert property (p_lat) else $error("latch pins");
endmodule
bind spc_port spc_port_props u_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .pslverr, .pin_out, .pin_oe_n,
  .slow_osc_en, .slow_osc_active, .timer_count_input, .ccu1_capture_in,
  .ccu2_alt_pin_req, .ser_mode, .ser_clk_drive);

// ---- tb/testbench.sv ----
// self-checking bench for the shared port
`timescale 1ns/1ps
module testbench;
  import spc_pkg::*;
  // ************
  // stimulus and checks
  // ************
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata;
  logic [3:0]    pstrb;
  logic [7:0]    pin_in, pin_out, pin_oe_n, ext_en, ext_val;
  logic          slow_osc_en, timer_count_input, slow_osc_active;
  logic          ccu2_capture_in, ccu2_alt_pin_req, ccu1_capture_in;
  logic          ser_clk_in;
  spc_drive_t    ccu2_drive, ccu1_drive, ser_clk_drive;
  spc_ser_mode_t ser_mode;
  int            error_cnt, comparisons;
  spc_port uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe_n,
    .slow_osc_en, .timer_count_input, .slow_osc_active, .ccu2_drive,
    .ccu2_capture_in, .ccu2_alt_pin_req, .ccu1_drive, .ccu1_capture_in,
    .ser_mode, .ser_clk_drive, .ser_clk_in);
  spc_board board (.pin_out, .pin_oe_n, .ext_en, .ext_val, .pin_in);
  // free-running 100 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer; an edge passes first so a strobe never toggles twice
  task automatic apb(input logic w, input logic [11:0] a, logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, logic [7:0] e, input string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, e, prdata[7:0]);
  endtask
  // pins are registered and inputs pass two sync flops
  task automatic wt;
    repeat (4) @(posedge pclk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // watchdog far beyond the hundred or so cycles the tests need
  initial
  begin
    #50000;
    error_cnt++;
    tally_and_finish;
  end
  initial
  begin
    {psel, penable, pwrite, slow_osc_en, ext_en, ext_val, paddr, pwdata,
      ccu1_drive, ccu2_drive, ser_clk_drive, error_cnt, comparisons} = '0;
    ser_mode = SPC_SER_OFF;
    pstrb = 4'h1;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h008, 8'hFF, "dir");
    rd(12'h00C, 8'h01, "ctrl");
    chk("oe_n", 8'hFF, pin_oe_n);
    apb(1'b1, 12'h008, 8'h00);
    apb(1'b1, 12'h004, 8'hA5);
    wt;
    chk("out", 8'hA5, pin_out);
    rd(12'h004, 8'hA5, "latch");
    rd(12'h000, 8'hA5, "levels");
    apb(1'b1, 12'h000, 8'h00);
    rd(12'h004, 8'h00, "latch");
    rd(12'h010, 8'h00, "unmapped");
    chk("slverr", 8'h01, 8'(pslverr));
    ext_en <= 8'hFF;
    ext_val <= 8'h57;
    apb(1'b1, 12'h008, 8'hF1);
    wt;
    chk("oe_n", 8'hF1, pin_oe_n);
    chk("count", 8'h01, 8'(timer_count_input));
    rd(12'h000, 8'h51, "levels");
    $display("test gpio done");
    @(posedge pclk);
    slow_osc_en <= 1'b1;
    wt;
    chk("count", 8'h00, 8'(timer_count_input));
    chk("osc act", 8'h01, 8'(slow_osc_active));
    rd(12'h008, 8'hF1, "dir");
    slow_osc_en <= 1'b0;
    ccu1_drive <= 3'b110;
    ccu2_drive <= 3'b110;
    wt;
    chk("out", 8'h06, pin_out & 8'h0E);
    @(posedge pclk);
    ccu1_drive <= 3'b111;
    ccu2_drive <= 3'b111;
    wt;
    chk("oe_n", 8'hF7, pin_oe_n);
    @(posedge pclk);
    ccu1_drive <= 3'b000;
    ccu2_drive <= 3'b000;
    apb(1'b1, 12'h008, 8'hF7);
    wt;
    chk("cap", 8'h03, {6'h0, ccu2_capture_in, ccu1_capture_in});
    apb(1'b1, 12'h00C, 8'h02);
    wt;
    chk("alt", 8'h01, 8'(ccu2_alt_pin_req));
    chk("cap", 8'h01, {6'h0, ccu2_capture_in, ccu1_capture_in});
    $display("test periph done");
    @(posedge pclk);
    ser_mode <= SPC_SER_SPI;
    ser_clk_drive <= 3'b110;
    wt;
    chk("sclk", 8'h08, pin_out & 8'h08);
    @(posedge pclk);
    ext_val <= 8'h5F;
    apb(1'b1, 12'h008, 8'hFF);
    wt;
    chk("sclk in", 8'h01, 8'(ser_clk_in));
    @(posedge pclk);
    ser_mode <= SPC_SER_I2C;
    ser_clk_drive <= 3'b100;
    wt;
    chk("scl", 8'h00, (pin_oe_n | pin_out) & 8'h08);
    @(posedge pclk);
    ser_mode <= SPC_SER_OFF;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h008, 8'hFF, "dir");
    $display("test serial done");
    tally_and_finish;
  end
endmodule
